// *** include/mrxfe_pkg.sv ***
// Shared constants of the receive front end host register block
package mrxfe_pkg;
   // Bus operation decoded from read/write and the two register selects
   typedef enum logic [5:0] {
      OP_NONE = 6'b00_0001,
      OP_WR_CTRL = 6'b00_0010,
      OP_WR_PTR = 6'b00_0100,
      OP_RD_RES = 6'b00_1000,
      OP_RD_LINE = 6'b01_0000,
      OP_RD_FLAG = 6'b10_0000
   } mrxfe_op_t;
   // Bus cycle tracker
   typedef enum logic [2:0] {
      BS_IDLE = 3'b001,
      BS_READ = 3'b010,
      BS_WRITE = 3'b100
   } mrxfe_bus_t;
   // Pin vector layout
   localparam int PIN_W = 17;
   localparam int PIN_STROBE = 0;
   localparam int PIN_RW = 1;
   localparam int PIN_CSL = 2;
   localparam int PIN_CSH = 3;
   localparam int PIN_RS0 = 4;
   localparam int PIN_RS1 = 5;
   localparam int PIN_DATA = 6;
   localparam int PIN_RXCLK = 14;
   localparam int PIN_TXCLK = 15;
   localparam int PIN_CARR = 16;
   // Pointer codes in bits 7..5
   localparam logic [2:0] PTR_FILTER = 3'h2;
   localparam logic [2:0] PTR_GAIN = 3'h4;
   localparam logic [2:0] PTR_THRESH = 3'h5;
   localparam int PTR_LSB = 5;
   // Filter configuration fields, then gain, threshold and flag bit positions
   localparam int FC_LOWCUT = 6;
   localparam int FC_HIGHCUT = 4;
   localparam int FC_NOTCH = 3;
   localparam int FC_ECHO = 2;
   localparam int FC_SMOOTH = 1;
   localparam int GAIN_LSB = 3;
   localparam int THR_LSB = 5;
   localparam int FLAG_BIT = 7;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] PTR_RST = 3'h0;
   localparam logic [11:0] SAMPLE_RST = 12'h000;
   // Carrier detector response time
   localparam int CARR_RESP_NS = 1780000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CARR_RESP_CYC = CARR_RESP_NS / CLK_PERIOD_NS;
endpackage

// *** include/mrxfe_sync_if.sv ***
// Interface between raw pins and their synchronised copies
`timescale 1ns/1ps
interface mrxfe_sync_if;
   logic [mrxfe_pkg::PIN_W-1:0] raw; // Pins as they arrive
   logic [mrxfe_pkg::PIN_W-1:0] clean; // Settled pin levels
   modport sync (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// *** src/mrxfe_pin_sync.sv ***
// Three-stage synchroniser with agreement filter for the pins
`timescale 1ns/1ps
module mrxfe_pin_sync (
   input wire logic sys_clk,
   input wire logic rst_n,
   mrxfe_sync_if.sync pins
);
   logic [mrxfe_pkg::PIN_W-1:0] stage1; // Only read by stage2
   logic [mrxfe_pkg::PIN_W-1:0] stage2; // Second stage
   logic [mrxfe_pkg::PIN_W-1:0] stage3; // Third stage
   logic [mrxfe_pkg::PIN_W-1:0] held; // Accepted level

   // Shift chain; metastability settles before stage2
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= pins.raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // A bit changes only once two stages agree, so one glitch is dropped
   genvar i;
   generate
      for (i = 0; i < mrxfe_pkg::PIN_W; i++) begin : g_bit
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               held[i] <= 1'b0;
            end else if (stage2[i] == stage3[i]) begin
               held[i] <= stage3[i];
            end
         end
      end
   endgenerate

   assign pins.clean = held;
endmodule

// *** src/modem_rx_frontend_host_regs.sv ***
// Host register bank of the modem receive front end
// Summary of operation
// - Respond only with low select 0, high 1
// - Read/write high reads, low writes
// - Strobe low reads, rising edge writes
// - Operation decoded from rw and selects
// - Four write-only, three read-only registers
// - Pointer bits 7..5 pick control register
// - Write captured on rise, pointer increments
// - Drive bus only while strobe low
// - Carrier flag on bit 7, others zero
// - Flag follows level, 1.78 ms response
// - Samples read low nibble then high byte
// - Byte latch advances on sample cycles
// - Other cycles return latch to first byte
// - Samples are 12-bit two's complement
// - Residual on transmit, line on receive
// - Filter bit 3 inserts notch filter
// - Filter bit 1 inserts smoothing filter
// - Filter bit 2 routes echo hold path
// - Bits 5..4 select high-cut corner
// - Samples load on conversion clock fall
// - Gain upper five bits, 1.5 dB steps
// - Threshold upper three bits, eight codes
`timescale 1ns/1ps
module modem_rx_frontend_host_regs #(
   parameter int CARR_RESP_CYCLES = mrxfe_pkg::CARR_RESP_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic enableStrobe_n,
   input wire logic readNotWrite,
   input wire logic selectLowActive_n,
   input wire logic selectHighActive,
   input wire logic regSelB0,
   input wire logic regSelB1,
   input wire logic [7:0] dataIn,
   output logic [7:0] dataOut,
   output logic dataOe_n,
   input wire logic receiveConversionClock,
   input wire logic transmitConversionClock,
   input wire logic [11:0] lineConvCode,
   input wire logic [11:0] residualConvCode,
   input wire logic carrierAboveThreshold,
   output logic lowCutSelB0,
   output logic lowCutSelB1,
   output logic highCutSelB0,
   output logic highCutSelB1,
   output logic notchFilterEnable,
   output logic smoothingFilterEnable,
   output logic echoSampleHold,
   output logic [4:0] gainCode,
   output logic [2:0] carrierThresholdCode,
   output logic carrierFlag
);
   // Synchronised copies of every pin except the converter codes
   mrxfe_sync_if pinBus ();

   // Group all asynchronous pins but the converter codes into one vector
   // The strobe travels inverted: the synchroniser clears to zero, and the
   // inverted copy turns that cleared value into the idle high strobe,
   // so no false strobe edge follows reset
   assign pinBus.raw = {carrierAboveThreshold,
                        transmitConversionClock,
                        receiveConversionClock,
                        dataIn, regSelB1, regSelB0,
                        selectHighActive, selectLowActive_n,
                        readNotWrite, !enableStrobe_n};

   // Pin synchroniser
   mrxfe_pin_sync u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pins(pinBus)
   );

   // Settled pin levels
   logic strobe_n; // Enable strobe, low active
   logic rwSel; // High for read
   logic chipSel; // Both chip selects valid
   logic [7:0] busData; // Write data from host
   logic rxClk; // Receive conversion clock
   logic txClk; // Transmit conversion clock
   logic carrAbove; // Analog comparator result

   assign strobe_n = !pinBus.clean[mrxfe_pkg::PIN_STROBE]; // Undo the pin inversion
   assign rwSel = pinBus.clean[mrxfe_pkg::PIN_RW];
   assign chipSel = !pinBus.clean[mrxfe_pkg::PIN_CSL]
                    && pinBus.clean[mrxfe_pkg::PIN_CSH];
   assign busData = pinBus.clean[mrxfe_pkg::PIN_DATA +: 8];
   assign rxClk = pinBus.clean[mrxfe_pkg::PIN_RXCLK];
   assign txClk = pinBus.clean[mrxfe_pkg::PIN_TXCLK];
   assign carrAbove = pinBus.clean[mrxfe_pkg::PIN_CARR];

   // Decode of the selects; a deselected chip sees no operation
   // Read/write with both register selects picks one of five operations
   function automatic mrxfe_pkg::mrxfe_op_t decodeOp(
      input logic sel,
      input logic rw,
      input logic rs0,
      input logic rs1
   );
      mrxfe_pkg::mrxfe_op_t op;
      op = mrxfe_pkg::OP_NONE;
      if (sel) begin
         unique case ({rw, rs0, rs1})
            3'b011: op = mrxfe_pkg::OP_WR_CTRL;
            3'b010: op = mrxfe_pkg::OP_WR_PTR;
            3'b101: op = mrxfe_pkg::OP_RD_RES;
            3'b100: op = mrxfe_pkg::OP_RD_LINE;
            3'b110: op = mrxfe_pkg::OP_RD_FLAG;
            default: op = mrxfe_pkg::OP_NONE;
         endcase
      end
      return op;
   endfunction

   // Operation seen at the present level of the selects
   mrxfe_pkg::mrxfe_op_t curOp;
   assign curOp = decodeOp(chipSel, rwSel,
                           pinBus.clean[mrxfe_pkg::PIN_RS0],
                           pinBus.clean[mrxfe_pkg::PIN_RS1]);

   // True when the current operation reads a sample register
   logic sampleAddr;
   assign sampleAddr = (curOp == mrxfe_pkg::OP_RD_RES)
                       || (curOp == mrxfe_pkg::OP_RD_LINE);

   // Edge detection on settled strobe and conversion clocks
   logic strobeLast; // Strobe one cycle ago
   logic rxLast; // Receive clock one cycle ago
   logic txLast; // Transmit clock one cycle ago
   logic strobeRise; // Write strobe edge
   logic strobeFall; // Start of a bus cycle
   logic rxFall; // Receive load moment
   logic txFall; // Transmit load moment

   // Previous levels equal the cleared synchroniser outputs, so reset
   // itself never shows an edge; an idle-high conversion clock only
   // shows a rise on its way up, which loads nothing
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobeLast <= 1'b1;
         rxLast <= 1'b0;
         txLast <= 1'b0;
      end else begin
         strobeLast <= strobe_n;
         rxLast <= rxClk;
         txLast <= txClk;
      end
   end

   assign strobeRise = strobe_n && !strobeLast;
   assign strobeFall = !strobe_n && strobeLast;
   assign rxFall = !rxClk && rxLast;
   assign txFall = !txClk && txLast;

   // Bus cycle tracker
   mrxfe_pkg::mrxfe_bus_t busState;
   mrxfe_pkg::mrxfe_bus_t next_busState;

   // Read phase is a level, write acts at the end of the pulse
   always_comb begin
      next_busState = busState;
      unique case (busState)
         mrxfe_pkg::BS_IDLE: begin
            if (strobeFall && chipSel) begin
               next_busState = rwSel ? mrxfe_pkg::BS_READ
                                     : mrxfe_pkg::BS_WRITE;
            end
         end
         mrxfe_pkg::BS_READ: begin
            if (strobe_n || !chipSel || !rwSel) begin
               next_busState = mrxfe_pkg::BS_IDLE;
            end
         end
         mrxfe_pkg::BS_WRITE: begin
            if (strobe_n) begin
               next_busState = mrxfe_pkg::BS_IDLE;
            end
         end
         default: next_busState = mrxfe_pkg::BS_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busState <= mrxfe_pkg::BS_IDLE;
      end else begin
         busState <= next_busState;
      end
   end

   // Write strobe: rising edge while a write cycle is decoded
   // Data and selects cross through the same synchroniser as the strobe,
   // and the host holds them past the rise, so they are settled here
   logic wrStrobe;
   assign wrStrobe = strobeRise && !rwSel && chipSel;

   // Address pointer, three stored bits only
   logic [2:0] ctrlPointer;

   // Loaded directly, stepped after every control write
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlPointer <= mrxfe_pkg::PTR_RST;
      end else if (wrStrobe && curOp == mrxfe_pkg::OP_WR_PTR) begin
         ctrlPointer <= busData[mrxfe_pkg::PTR_LSB +: 3];
      end else if (wrStrobe && curOp == mrxfe_pkg::OP_WR_CTRL) begin
         ctrlPointer <= ctrlPointer + 3'h1;
      end
   end

   // Control registers, reachable only through the pointer
   logic [7:0] filterConfig;
   logic [7:0] gainReg;
   logic [7:0] thresholdReg;

   // Unused pointer codes still step the pointer but store nothing
   // The reset to zero only gives a known start; software must still
   // program every control register before it reads a sample
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         filterConfig <= mrxfe_pkg::CTRL_RST;
         gainReg <= mrxfe_pkg::CTRL_RST;
         thresholdReg <= mrxfe_pkg::CTRL_RST;
      end else if (wrStrobe && curOp == mrxfe_pkg::OP_WR_CTRL) begin
         unique case (ctrlPointer)
            mrxfe_pkg::PTR_FILTER: filterConfig <= busData;
            mrxfe_pkg::PTR_GAIN: gainReg <= busData;
            mrxfe_pkg::PTR_THRESH: thresholdReg <= busData;
            default: ;
         endcase
      end
   end

   // Analog control outputs
   assign lowCutSelB1 = filterConfig[mrxfe_pkg::FC_LOWCUT + 1];
   assign lowCutSelB0 = filterConfig[mrxfe_pkg::FC_LOWCUT];
   assign highCutSelB1 = filterConfig[mrxfe_pkg::FC_HIGHCUT + 1];
   assign highCutSelB0 = filterConfig[mrxfe_pkg::FC_HIGHCUT];
   assign notchFilterEnable = filterConfig[mrxfe_pkg::FC_NOTCH];
   assign echoSampleHold = filterConfig[mrxfe_pkg::FC_ECHO];
   assign smoothingFilterEnable = filterConfig[mrxfe_pkg::FC_SMOOTH];
   assign gainCode = gainReg[mrxfe_pkg::GAIN_LSB +: 5];
   assign carrierThresholdCode = thresholdReg[mrxfe_pkg::THR_LSB +: 3];

   // Sample registers, two's complement from the converter
   logic [11:0] lineSample;
   logic [11:0] residualSample;

   // Each register loads on the falling edge of its own clock
   // The converter code must stay still for a few cycles past the fall,
   // since the settled clock edge arrives late
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lineSample <= mrxfe_pkg::SAMPLE_RST;
      end else if (rxFall) begin
         lineSample <= lineConvCode;
      end
   end

   // Residual channel follows the transmit clock
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         residualSample <= mrxfe_pkg::SAMPLE_RST;
      end else if (txFall) begin
         residualSample <= residualConvCode;
      end
   end

   // Byte select latch; low picks the first byte
   logic secondByte;

   // Steps on every sample cycle, cleared by any other cycle
   // A deselected strobe counts as another cycle and clears the latch too
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         secondByte <= 1'b0;
      end else if (strobeRise) begin
         if (sampleAddr) begin
            secondByte <= !secondByte;
         end else begin
            secondByte <= 1'b0;
         end
      end
   end

   // Carrier detector with response filter
   logic [$clog2(CARR_RESP_CYCLES + 1)-1:0] carrCount;
   logic carrState;

   // The flag follows only a level held for the full response time
   // Any return of the level restarts the count, so a short blip is lost
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         carrCount <= '0;
         carrState <= 1'b0;
      end else if (carrAbove == carrState) begin
         carrCount <= '0;
      end else if (carrCount == ($bits(carrCount))'(CARR_RESP_CYCLES - 1)) begin
         carrCount <= '0;
         carrState <= carrAbove;
      end else begin
         carrCount <= carrCount + 1'b1;
      end
   end

   assign carrierFlag = carrState;

   // Byte selected by the current read operation
   logic [7:0] readByte;
   logic [11:0] pickSample;

   // Nibble then byte; unmapped reads return zero
   always_comb begin
      pickSample = (curOp == mrxfe_pkg::OP_RD_RES) ? residualSample
                                                   : lineSample;
      readByte = 8'h00;
      if (sampleAddr) begin
         readByte = secondByte ? pickSample[11:4]
                               : {pickSample[3:0], 4'h0};
      end else if (curOp == mrxfe_pkg::OP_RD_FLAG) begin
         readByte[mrxfe_pkg::FLAG_BIT] = carrState;
      end
   end

   // Registered read data and low-active drive enable
   // Release lags the settled strobe rise by one cycle; the host's
   // recovery time between cycles covers it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dataOut <= 8'h00;
         dataOe_n <= 1'b1;
      end else begin
         dataOut <= readByte;
         dataOe_n <= !(next_busState == mrxfe_pkg::BS_READ
                       && !strobe_n && curOp != mrxfe_pkg::OP_NONE);
      end
   end
endmodule

// *** tb/mrxfe_regs_sva.sv ***
// Port-level assertions for the host register block
`timescale 1ns/1ps
module mrxfe_regs_sva #(
   parameter int CARR_RESP_CYCLES = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic enableStrobe_n,
   input wire logic readNotWrite,
   input wire logic selectLowActive_n,
   input wire logic selectHighActive,
   input wire logic regSelB0,
   input wire logic regSelB1,
   input wire logic [7:0] dataOut,
   input wire logic dataOe_n,
   input wire logic carrierAboveThreshold,
   input wire logic [4:0] gainCode,
   input wire logic [2:0] carrierThresholdCode,
   input wire logic carrierFlag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Chip selected; eight cycles covers the pin synchroniser delay
   logic chipSel;
   assign chipSel = !selectLowActive_n && selectHighActive;
   sequence s_readHeld;
      (!enableStrobe_n && chipSel && readNotWrite && !(regSelB0 && regSelB1)) [*8];
   endsequence
   sequence s_flagHeld;
      (!enableStrobe_n && chipSel && readNotWrite && regSelB0 && !regSelB1) [*8];
   endsequence
   property p_drive;
      s_readHeld |-> !dataOe_n;
   endproperty
   a_drive: assert property (p_drive) else $error("read cycle not driven");
   property p_release;
      enableStrobe_n [*8] |-> dataOe_n;
   endproperty
   a_release: assert property (p_release) else $error("bus driven with strobe high");
   property p_desel;
      (!chipSel) [*8] |-> dataOe_n;
   endproperty
   a_desel: assert property (p_desel) else $error("bus driven while deselected");
   property p_write;
      (!readNotWrite) [*8] |-> dataOe_n;
   endproperty
   a_write: assert property (p_write) else $error("bus driven during write");
   property p_flag;
      s_flagHeld |-> !dataOe_n && dataOut[6:0] == 7'h00;
   endproperty
   a_flag: assert property (p_flag) else $error("flag byte low bits not zero");
   property p_ctrl;
      readNotWrite [*8] |-> $stable({gainCode, carrierThresholdCode});
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control changed without write");
   // Flag may only move after a settled comparator level
   property p_rise;
      $rose(carrierFlag) |-> $past(carrierAboveThreshold, 2) && $past(carrierAboveThreshold, 8);
   endproperty
   a_rise: assert property (p_rise) else $error("flag rose too early");
   property p_fall;
      $fell(carrierFlag) |-> !$past(carrierAboveThreshold, 2) && !$past(carrierAboveThreshold, 8);
   endproperty
   a_fall: assert property (p_fall) else $error("flag fell too early");
   // Consecutive cycles in which the comparator has disagreed with the flag
   int diffRun;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         diffRun <= 0;
      end else if (carrierAboveThreshold == carrierFlag) begin
         diffRun <= 0;
      end else begin
         diffRun <= diffRun + 1;
      end
   end
   // Flag moves only after a full response count of disagreement
   property p_hold;
      $changed(carrierFlag) |-> diffRun >= CARR_RESP_CYCLES;
   endproperty
   a_hold: assert property (p_hold) else $error("flag moved before response time");
endmodule
bind modem_rx_frontend_host_regs mrxfe_regs_sva #(.CARR_RESP_CYCLES(CARR_RESP_CYCLES)) i_mrxfe_regs_sva (
   .sys_clk(sys_clk), .rst_n(rst_n), .enableStrobe_n(enableStrobe_n), .readNotWrite(readNotWrite),
   .selectLowActive_n(selectLowActive_n), .selectHighActive(selectHighActive), .regSelB0(regSelB0),
   .regSelB1(regSelB1), .dataOut(dataOut), .dataOe_n(dataOe_n), .carrierAboveThreshold(carrierAboveThreshold),
   .gainCode(gainCode), .carrierThresholdCode(carrierThresholdCode), .carrierFlag(carrierFlag));

// *** tb/mrxfe_host_model.sv ***
// Signal processor model driving the host bus pins
`timescale 1ns/1ps
module mrxfe_host_model (
   input wire logic sys_clk,
   input wire logic [7:0] dataOut,
   input wire logic dataOe_n,
   output logic enableStrobe_n,
   output logic readNotWrite,
   output logic selectLowActive_n,
   output logic selectHighActive,
   output logic regSelB0,
   output logic regSelB1,
   output logic [7:0] dataIn
);
   logic hostDrive; // Host owns the data lines
   logic [7:0] hostData;
   logic [7:0] lastWire; // Level seen at the last edge
   // A released bus shows the inverse of its last level, so stale data never matches
   assign dataIn = !dataOe_n ? dataOut : (hostDrive ? hostData : ~lastWire);
   always @(posedge sys_clk) lastWire <= dataIn;
   initial begin
      enableStrobe_n = 1'b1;
      readNotWrite = 1'b1;
      selectLowActive_n = 1'b1;
      selectHighActive = 1'b0;
      regSelB0 = 1'b0;
      regSelB1 = 1'b0;
      hostDrive = 1'b0;
      hostData = 8'h00;
      lastWire = 8'h00;
   end
   // One bus cycle; pins are held eight edges past the strobe rise for the synchroniser
   task automatic cycle(input logic rw, input logic rs0, input logic rs1, input logic sel,
      input logic [7:0] wData, output logic [7:0] rData, output logic driven);
      @(posedge sys_clk);
      #1;
      readNotWrite = rw;
      regSelB0 = rs0;
      regSelB1 = rs1;
      selectLowActive_n = !sel;
      selectHighActive = sel;
      hostDrive = !rw;
      hostData = wData;
      driven = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      enableStrobe_n = 1'b0;
      repeat (8) begin
         @(posedge sys_clk);
         if (dataOe_n === 1'b0) driven = 1'b1;
      end
      rData = dataIn;
      #1;
      enableStrobe_n = 1'b1;
      repeat (8) @(posedge sys_clk);
      #1;
      hostDrive = 1'b0;
      selectLowActive_n = 1'b1;
      selectHighActive = 1'b0;
   endtask
endmodule

// *** tb/modem_rx_frontend_host_regs_bench.sv ***
// Self-checking bench for the host register block
`timescale 1ns/1ps
module modem_rx_frontend_host_regs_bench;
   localparam int RESP = 8; // Shortened carrier response count
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic enableStrobe_n, readNotWrite, selectLowActive_n, selectHighActive, regSelB0, regSelB1;
   logic [7:0] dataIn, dataOut, rd;
   logic dataOe_n, drv;
   logic rxClk = 1'b1;
   logic txClk = 1'b1;
   logic carrIn = 1'b0;
   logic [11:0] lineCode = 12'h000;
   logic [11:0] resCode = 12'h000;
   logic lcB0, lcB1, hcB0, hcB1, notch, smooth, echo, flag;
   logic [4:0] gain;
   logic [2:0] thr;
   int err_count = 0;
   int compares = 0;
   always #20 sys_clk = ~sys_clk;
   modem_rx_frontend_host_regs #(.CARR_RESP_CYCLES(RESP)) i_modem_rx_frontend_host_regs (
      .sys_clk(sys_clk), .rst_n(rst_n), .enableStrobe_n(enableStrobe_n), .readNotWrite(readNotWrite),
      .selectLowActive_n(selectLowActive_n), .selectHighActive(selectHighActive), .regSelB0(regSelB0),
      .regSelB1(regSelB1), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
      .receiveConversionClock(rxClk), .transmitConversionClock(txClk), .lineConvCode(lineCode),
      .residualConvCode(resCode), .carrierAboveThreshold(carrIn), .lowCutSelB0(lcB0), .lowCutSelB1(lcB1),
      .highCutSelB0(hcB0), .highCutSelB1(hcB1), .notchFilterEnable(notch), .smoothingFilterEnable(smooth),
      .echoSampleHold(echo), .gainCode(gain), .carrierThresholdCode(thr), .carrierFlag(flag));
   mrxfe_host_model i_mrxfe_host_model (
      .sys_clk(sys_clk), .dataOut(dataOut), .dataOe_n(dataOe_n), .enableStrobe_n(enableStrobe_n),
      .readNotWrite(readNotWrite), .selectLowActive_n(selectLowActive_n), .selectHighActive(selectHighActive),
      .regSelB0(regSelB0), .regSelB1(regSelB1), .dataIn(dataIn));
   task automatic end_of_test();
      $display("Counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic rw, input logic rs0, input logic rs1, input logic [7:0] wd);
      i_mrxfe_host_model.cycle(rw, rs0, rs1, 1'b1, wd, rd, drv);
   endtask
   // Read one byte and demand that the device drove it
   task automatic rdChk(input string what, input logic rs0, input logic rs1, input logic [7:0] exp);
      acc(1'b1, rs0, rs1, 8'h00);
      chk(what, exp, rd);
      chk("drive", 1'b1, drv);
   endtask
   // Falling edge of a conversion clock, code held well past it
   task automatic conv(input logic tx);
      @(posedge sys_clk);
      #1;
      if (tx) txClk = 1'b0;
      else rxClk = 1'b0;
      repeat (8) @(posedge sys_clk);
      #1;
      txClk = 1'b1;
      rxClk = 1'b1;
   endtask
   // Bounded wait for the carrier flag; a hang ends the run
   task automatic waitFlag(input logic v);
      int n;
      n = 0;
      while (flag !== v && n < 60) begin
         @(posedge sys_clk);
         n++;
      end
      if (flag !== v) begin
         err_count++;
         $display("CHECK FAILED carrierFlag expected %b seen %b", v, flag);
         end_of_test();
      end
      chk("flag delay", 1'b1, n >= RESP);
   endtask
   initial begin
      #2000000;
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      repeat (6) @(posedge sys_clk);
      rdChk("flag idle", 1'b1, 1'b0, 8'h00);
      acc(1'b0, 1'b1, 1'b0, 8'h40);
      acc(1'b0, 1'b1, 1'b1, 8'hDA);
      acc(1'b0, 1'b1, 1'b1, 8'hFF);
      acc(1'b0, 1'b1, 1'b1, 8'hAB);
      acc(1'b0, 1'b1, 1'b1, 8'h7F);
      chk("filter", 12'h06D, {lcB1, lcB0, hcB1, hcB0, notch, echo, smooth});
      chk("gain", 12'h015, gain);
      chk("thresh", 12'h003, thr);
      // Unmapped codes 6, 7, 0, 1 then the wrap lands on the filter again
      repeat (4) acc(1'b0, 1'b1, 1'b1, 8'h00);
      acc(1'b0, 1'b1, 1'b1, 8'h25);
      chk("filter wrap", 12'h012, {lcB1, lcB0, hcB1, hcB0, notch, echo, smooth});
      chk("gain kept", 12'h015, gain);
      $display("control registers test done");
      lineCode = 12'h8B1;
      resCode = 12'h7FF;
      conv(1'b0);
      conv(1'b1);
      rdChk("line lo", 1'b0, 1'b0, 8'h10);
      rdChk("line hi", 1'b0, 1'b0, 8'h8B);
      rdChk("line lo again", 1'b0, 1'b0, 8'h10);
      rdChk("flag", 1'b1, 1'b0, 8'h00);
      rdChk("res lo", 1'b0, 1'b1, 8'hF0);
      acc(1'b0, 1'b1, 1'b0, 8'h00);
      rdChk("res lo after write", 1'b0, 1'b1, 8'hF0);
      rdChk("res hi", 1'b0, 1'b1, 8'h7F);
      lineCode = 12'h800;
      conv(1'b0);
      rdChk("flag", 1'b1, 1'b0, 8'h00);
      rdChk("min lo", 1'b0, 1'b0, 8'h00);
      rdChk("min hi", 1'b0, 1'b0, 8'h80);
      $display("sample registers test done");
      i_mrxfe_host_model.cycle(1'b1, 1'b1, 1'b0, 1'b0, 8'h00, rd, drv);
      chk("deselected drive", 1'b0, drv);
      acc(1'b1, 1'b1, 1'b1, 8'h00);
      chk("no-op drive", 1'b0, drv);
      $display("refused cycles test done");
      @(posedge sys_clk);
      #1;
      carrIn = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      carrIn = 1'b0;
      repeat (30) @(posedge sys_clk);
      chk("blip ignored", 1'b0, flag);
      #1;
      carrIn = 1'b1;
      waitFlag(1'b1);
      rdChk("flag on", 1'b1, 1'b0, 8'h80);
      #1;
      carrIn = 1'b0;
      waitFlag(1'b0);
      rdChk("flag off", 1'b1, 1'b0, 8'h00);
      $display("carrier flag test done");
      end_of_test();
   end
endmodule
